// ### src/eep_pkg.sv
package eep_pkg;
  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 13;                // byte address width
  localparam int MEM_BYTES = 8192;           // array size in bytes
  localparam int PAGE_W = 5;                 // in-page address width
  localparam int PAGE_BYTES = 32;            // page size in bytes
  // ------------------------------------------------------------
  // select byte layout
  // ------------------------------------------------------------
  localparam logic [3:0] SEL_PREFIX = 4'hA;  // memory-class prefix
  localparam int SEL_PFX_LSB = 4;            // prefix field position
  localparam int SEL_STRAP_LSB = 1;          // strap field position
  localparam int SEL_RW_BIT = 0;             // high selects read
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ------------------------------------------------------------
  // input synchroniser lanes
  // ------------------------------------------------------------
  localparam int SYNC_W = 6;                 // wp,a2,a1,a0,sda,scl
  localparam int LN_SCL = 0;
  localparam int LN_SDA = 1;
  localparam int LN_STRAP = 2;               // three strap lanes from here
  localparam int LN_WP = 5;
  localparam logic [5:0] SYNC_RST = 6'h03;   // bus lines idle high
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;         // ref_clk period
  localparam int WR_TIME_NS = 5000000;       // longest write cycle, 5 ms
  localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;  // rounds down
  localparam int WR_CNT_W = 17;
  // ------------------------------------------------------------
  // protocol states
  // ------------------------------------------------------------
  typedef enum logic [10:0] {
    ST_IDLE   = 11'h001,
    ST_SEL    = 11'h002,
    ST_SELACK = 11'h004,
    ST_AHI    = 11'h008,
    ST_AHIACK = 11'h010,
    ST_ALO    = 11'h020,
    ST_ALOACK = 11'h040,
    ST_WDAT   = 11'h080,
    ST_WACK   = 11'h100,
    ST_RDAT   = 11'h200,
    ST_RACK   = 11'h400
  } eep_state_t;
endpackage : eep_pkg

// ### src/eep_sync.sv
// ------------------------------------------------------------
// two-flop synchroniser for every asynchronous pin
// ------------------------------------------------------------
module eep_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [eep_pkg::SYNC_W-1:0] async_in,
  output logic [eep_pkg::SYNC_W-1:0] sync_out
);
  import eep_pkg::*;

  genvar g;
  // one pair of flops per lane; first stage feeds only the second
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_lane
      logic meta_r; // first stage
      logic hold_r; // second stage
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          meta_r <= SYNC_RST[g];
          hold_r <= SYNC_RST[g];
        end else begin
          meta_r <= async_in[g];
          hold_r <= meta_r;
        end
      end
      assign sync_out[g] = hold_r;
    end
  endgenerate
endmodule : eep_sync

// ### src/eep_target.sv
module eep_target #(
  parameter int WRITE_CYCLES = eep_pkg::WR_CYCLES  // self-timed write length
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic write_protect,
  output logic write_busy
);
  import eep_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisation and edge detection
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s; // synchronised pins
  logic scl_d_r; // previous clock level
  logic sda_d_r; // previous data level
  logic [2:0] strap_lvl; // strap levels, undriven as low
  logic wp_lvl; // protect level, undriven as low

  eep_sync u_sync (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .async_in ({write_protect, select_strap_bit2, select_strap_bit1,
                select_strap_bit0, sda_in, scl_in}),
    .sync_out (pins_s)
  );

  // only a clean high counts; a floating pin falls to low
  always_comb begin
    strap_lvl = 3'h0;
    wp_lvl = 1'b0;
    if (pins_s[LN_STRAP] == 1'b1) strap_lvl[0] = 1'b1;
    if (pins_s[LN_STRAP+1] == 1'b1) strap_lvl[1] = 1'b1;
    if (pins_s[LN_STRAP+2] == 1'b1) strap_lvl[2] = 1'b1;
    if (pins_s[LN_WP] == 1'b1) wp_lvl = 1'b1;
  end

  // remember last levels for edge finding
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= pins_s[LN_SCL];
      sda_d_r <= pins_s[LN_SDA];
    end
  end

  wire scl_q = pins_s[LN_SCL];
  wire sda_q = pins_s[LN_SDA];
  wire scl_rise = scl_q & ~scl_d_r;
  wire scl_fall = ~scl_q & scl_d_r;
  // start and stop need the clock high, which the host keeps when idle
  wire bus_start = scl_q & scl_d_r & sda_d_r & ~sda_q;
  wire bus_stop = scl_q & scl_d_r & ~sda_d_r & sda_q;

  // ------------------------------------------------------------
  // state and datapath registers
  // ------------------------------------------------------------
  eep_state_t st_r; // protocol state
  logic [7:0] shift_r; // incoming byte
  logic [3:0] bit_cnt_r; // bits seen in current byte
  logic [7:0] tx_r; // outgoing byte
  logic drive_r; // pull data line low
  logic [ADDR_W-1:0] addr_r; // byte address pointer
  logic [7:0] mem [MEM_BYTES]; // the array
  logic [7:0] page_buf [PAGE_BYTES]; // page being collected
  logic [PAGE_BYTES-1:0] page_mask_r; // bytes present in page
  logic [WR_CNT_W-1:0] wr_cnt_r; // write cycle timer
  logic busy_r; // self-timed write running

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire byte_done = (bit_cnt_r == BITS_PER_BYTE);
  wire [7:0] rx_byte = shift_r;
  wire sel_match = (rx_byte[7:SEL_PFX_LSB] == SEL_PREFIX) &&
                   (rx_byte[SEL_STRAP_LSB+2:SEL_STRAP_LSB] == strap_lvl)
                   && !busy_r;
  wire sel_read = rx_byte[SEL_RW_BIT];
  wire [PAGE_W-1:0] page_idx = addr_r[PAGE_W-1:0];
  wire [PAGE_W-1:0] page_idx_nxt = page_idx + 1'b1; // wraps in page
  wire [ADDR_W-1:0] addr_inc = addr_r + 1'b1; // whole-array wrap for reads
  wire commit_go = bus_stop && (page_mask_r != '0) && !wp_lvl;
  wire [WR_CNT_W-1:0] wr_last = WR_CNT_W'(WRITE_CYCLES - 1);
  wire in_commit = busy_r && (wr_cnt_r < WR_CNT_W'(PAGE_BYTES));
  wire [PAGE_W-1:0] commit_idx = wr_cnt_r[PAGE_W-1:0];
  wire [ADDR_W-1:0] commit_addr = {addr_r[ADDR_W-1:PAGE_W], commit_idx};
  wire rx_state = (st_r == ST_SEL) || (st_r == ST_AHI) ||
                  (st_r == ST_ALO) || (st_r == ST_WDAT);

  // ------------------------------------------------------------
  // protocol state machine
  // ------------------------------------------------------------
  // bits enter on clock rise, line changes on clock fall and is released at start or stop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      drive_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (bus_start) begin
      // start or repeated start: listen for a select byte
      st_r <= ST_SEL;
      bit_cnt_r <= 4'h0;
      drive_r <= 1'b0;
    end else if (bus_stop) begin
      st_r <= ST_IDLE;
      drive_r <= 1'b0;
    end else if (scl_rise) begin
      // sample the line
      if (rx_state || st_r == ST_RACK) begin
        shift_r <= {shift_r[6:0], sda_q};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end else if (scl_fall) begin
      case (st_r)
        ST_SEL: begin
          if (byte_done) begin
            bit_cnt_r <= 4'h0;
            if (sel_match) begin
              st_r <= ST_SELACK;
              drive_r <= 1'b1;
            end else begin
              st_r <= ST_IDLE; // not ours: stay off the line
            end
          end
        end
        ST_SELACK: begin
          if (sel_read) begin
            // current-address or random read begins
            st_r <= ST_RDAT;
            drive_r <= ~mem[addr_r][7];
            tx_r <= {mem[addr_r][6:0], 1'b0};
          end else begin
            st_r <= ST_AHI;
            drive_r <= 1'b0;
          end
        end
        ST_AHI, ST_ALO, ST_WDAT: begin
          if (byte_done) begin
            bit_cnt_r <= 4'h0;
            drive_r <= 1'b1;
            st_r <= (st_r == ST_AHI) ? ST_AHIACK :
                    (st_r == ST_ALO) ? ST_ALOACK : ST_WACK;
          end
        end
        ST_AHIACK: begin
          st_r <= ST_ALO;
          drive_r <= 1'b0;
        end
        ST_ALOACK, ST_WACK: begin
          st_r <= ST_WDAT;
          drive_r <= 1'b0;
        end
        ST_RDAT: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == BITS_PER_BYTE - 4'h1) begin
            st_r <= ST_RACK;
            drive_r <= 1'b0; // release for host acknowledge
            bit_cnt_r <= 4'h0;
          end else begin
            drive_r <= ~tx_r[7]; // next bit after fall
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          bit_cnt_r <= 4'h0;
          if (!shift_r[0]) begin
            // host acknowledged: next location follows
            st_r <= ST_RDAT;
            drive_r <= ~mem[addr_r][7];
            tx_r <= {mem[addr_r][6:0], 1'b0};
          end else begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          drive_r <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // address pointer and page collection
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_r <= '0;
      page_mask_r <= '0;
    end else if (scl_fall && byte_done) begin
      case (st_r)
        ST_AHI: addr_r[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
        ST_ALO: begin
          addr_r[7:0] <= rx_byte;
          page_mask_r <= '0; // fresh page for this transfer
        end
        ST_WDAT: begin
          // partial or full page, index wraps in the page
          page_mask_r[page_idx] <= 1'b1;
          addr_r[PAGE_W-1:0] <= page_idx_nxt;
        end
        default: addr_r <= addr_r;
      endcase
    end else if (scl_fall && st_r == ST_SELACK && sel_read) begin
      addr_r <= addr_inc; // pointer moves past byte sent
    end else if (scl_fall && st_r == ST_RACK && !shift_r[0]) begin
      addr_r <= addr_inc;
    end else if (busy_r && wr_cnt_r == wr_last) begin
      page_mask_r <= '0;
    end else if (bus_stop && wp_lvl) begin
      page_mask_r <= '0; // protected: collected page is dropped
    end
  end

  // page bytes held until the write cycle
  always_ff @(posedge ref_clk) begin
    if (scl_fall && byte_done && st_r == ST_WDAT) begin
      page_buf[page_idx] <= rx_byte;
    end
  end

  // ------------------------------------------------------------
  // self-timed write cycle
  // ------------------------------------------------------------
  // timer runs a fixed length that fits inside the longest time
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      wr_cnt_r <= '0;
    end else if (!busy_r) begin
      busy_r <= commit_go;
      wr_cnt_r <= '0;
    end else if (wr_cnt_r == wr_last) begin
      busy_r <= 1'b0;
    end else begin
      wr_cnt_r <= wr_cnt_r + 1'b1;
    end
  end

  // one page byte programmed per cycle at the start of the timer
  always_ff @(posedge ref_clk) begin
    if (in_commit && page_mask_r[commit_idx]) begin
      mem[commit_addr] <= page_buf[commit_idx];
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  assign sda_out = 1'b0; // only ever pulls low
  assign sda_oe_n = ~drive_r; // released otherwise
  assign write_busy = busy_r;
endmodule : eep_target

// ### tb/eep_host.sv
// ------------------------------------------------------------
// bus host: low 5 cycles, high 3 cycles per bit
// ------------------------------------------------------------
module eep_host (
  input wire logic ref_clk,
  input wire logic bus_sda,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;  // idle high
    sda_drv = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tk
  // data moves only while the clock is low
  task automatic xb(input logic b, output logic s);
    scl <= 1'b0;
    tk(1);
    sda_drv <= b;
    tk(4);
    scl <= 1'b1;
    tk(2);
    @(negedge ref_clk) s = bus_sda;
    tk(1);
  endtask : xb
  task automatic start();
    scl <= 1'b0;
    tk(1);
    sda_drv <= 1'b1;
    tk(4);
    scl <= 1'b1;
    tk(3);
    sda_drv <= 1'b0;
    tk(4);
  endtask : start
  task automatic stop();
    scl <= 1'b0;
    tk(1);
    sda_drv <= 1'b0;
    tk(4);
    scl <= 1'b1;
    tk(3);
    sda_drv <= 1'b1;
    tk(1);
  endtask : stop
  // byte out, msb first, then sample acknowledge
  task automatic wr(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) xb(b[i], a);
    xb(1'b1, a);
  endtask : wr
  task automatic rd(output logic [7:0] d, input logic m);
    logic s;
    for (int i = 7; i >= 0; i--) xb(1'b1, d[i]);
    xb(m, s);
  endtask : rd
endmodule : eep_host

// ### tb/eep_target_properties.sv
// ------------------------------------------------------------
// port checker for the two-wire target
// ------------------------------------------------------------
module eep_target_chk #(
  parameter int WRITE_CYCLES = 64
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic write_protect,
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] fall_h;  // recent clock falls
  logic [7:0] stop_h;  // recent stops
  logic ps;
  logic pd;
  int bcnt;  // busy length so far
  // edge history of the pins
  always_ff @(posedge ref_clk) begin
    ps <= scl_in;
    pd <= sda_in;
    fall_h <= {fall_h[6:0], ps & ~scl_in};
    stop_h <= {stop_h[6:0], ps & scl_in & ~pd & sda_in};
    bcnt <= write_busy ? bcnt + 1 : 0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  AST_DRIVE_AFTER_FALL: assert property ($fell(sda_oe_n) |-> |fall_h[7:1])
    else $error("data line pulled low away from a clock fall");
  AST_STABLE_HIGH: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("data output moved while clock high");
  AST_BUSY_AFTER_STOP: assert property ($rose(write_busy) |-> |stop_h)
    else $error("write cycle began without a stop");
  AST_BUSY_BOUND: assert property (bcnt <= WRITE_CYCLES)
    else $error("write cycle too long");
  AST_PROTECT: assert property ($rose(write_busy) |-> !$past(write_protect, 6))
    else $error("write cycle while protected");
  AST_QUIET_BUSY: assert property (write_busy |-> sda_oe_n)
    else $error("device answered while busy");
  AST_RESET: assert property (disable iff (1'b0) !rst_n |=> sda_oe_n && !write_busy)
    else $error("outputs not idle after reset");
  cover property ($rose(write_busy));
  cover property ($fell(sda_oe_n));
  cover property (write_protect && |stop_h);
endmodule : eep_target_chk

bind eep_target eep_target_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect(write_protect),
  .write_busy(write_busy));

// ### tb/eep_target_tb.sv
module eep_target_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import eep_pkg::*;
  localparam int WC = 128;  // long enough to poll the target while it is busy
  localparam logic [7:0] SW = {SEL_PREFIX, 3'h5, 1'h0};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp, sda_out, sda_oe_n, busy, scl, sdh;
  logic [2:0] st;
  int n_mismatch = 0;
  int n_compared = 0;
  // open-drain line with pull-up
  wire logic sda = sdh & (sda_oe_n | sda_out);
  initial forever #20 ref_clk = ~ref_clk;
  eep_host u_h (.ref_clk(ref_clk), .bus_sda(sda), .scl(scl), .sda_drv(sdh));
  eep_target #(.WRITE_CYCLES(WC)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .select_strap_bit0(st[0]), .select_strap_bit1(st[1]),
    .select_strap_bit2(st[2]), .write_protect(wp), .write_busy(busy));
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic wb(input logic [7:0] b);
    logic a;
    u_h.wr(b, a);
    chk("ack", 8'h00, {7'h0, a});
  endtask : wb
  // count busy cycles after a stop
  task automatic wfin(input logic on);
    int n;
    n = 0;
    repeat (WC + 40) @(negedge ref_clk) n += (busy === 1'b1);
    @(posedge ref_clk);
    chk("busy", on ? 8'(WC) : 8'h00, 8'(n));
  endtask : wfin
  task automatic rda(input logic [7:0] hi, lo);
    u_h.start();
    wb(SW);
    wb(hi);
    wb(lo);
    u_h.start();
    wb(SW | 8'h01);
  endtask : rda
  task automatic t_page();
    logic [7:0] d;
    logic a;
    u_h.start();
    wb(SW);
    wb(8'h1F);
    wb(8'h1E);
    wb(8'h11);
    wb(8'h22);
    wb(8'h33);
    u_h.stop();
    // select sent while the write cycle runs must go unanswered
    fork
      wfin(1'b1);
      begin
        u_h.start();
        u_h.wr(SW, a);
        chk("busy_sel", 8'h01, {7'h0, a});
        u_h.stop();
      end
    join
    rda(8'h1F, 8'h1E);
    u_h.rd(d, 1'b0);
    chk("rd0", 8'h11, d);
    u_h.rd(d, 1'b1);
    chk("rd1", 8'h22, d);
    u_h.stop();
    rda(8'h1F, 8'h00);
    u_h.rd(d, 1'b1);
    chk("wrap", 8'h33, d);
    u_h.stop();
    $display("page test done");
  endtask : t_page
  task automatic t_prot();
    logic [7:0] d;
    wp <= 1'b1;
    u_h.start();
    wb(SW);
    wb(8'h1F);
    wb(8'h1E);
    wb(8'h5A);
    u_h.stop();
    wfin(1'b0);
    wp <= 1'b0;
    rda(8'h1F, 8'h1E);
    u_h.rd(d, 1'b1);
    chk("prot", 8'h11, d);
    u_h.stop();
    $display("protect test done");
  endtask : t_prot
  task automatic t_sel();
    logic a;
    logic [7:0] d;
    u_h.start();
    u_h.wr({SEL_PREFIX, 3'h4, 1'b0}, a);
    chk("strap", 8'h01, {7'h0, a});
    u_h.stop();
    u_h.start();
    u_h.wr(8'hBA, a);
    chk("prefix", 8'h01, {7'h0, a});
    u_h.stop();
    st <= 3'bzzz;
    u_h.start();
    wb({SEL_PREFIX, 4'h1});
    u_h.rd(d, 1'b1);
    chk("cur", 8'h22, d);
    u_h.stop();
    $display("select test done");
  endtask : t_sel
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    wp = 1'b0;
    st = 3'h5;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_page();
    t_prot();
    t_sel();
    tally_and_finish();
  end
endmodule : eep_target_tb
